// File: inc/esc_defines.svh
// Purpose: shared constants of the eight-line serial scanner
// Assumes: system clock of 100 MHz
// Notes: times are kept as printed, cycle counts derive from them
`ifndef ESC_DEFINES_SVH
`define ESC_DEFINES_SVH
`define ESC_CLK_MHZ 100
`define ESC_SYS_KHZ 18'h186A0
`define ESC_MASTER_KHZ 18'h013CC
`define ESC_PHASE_DIV 3'h5
`define ESC_SLOT_NS 4000
`define ESC_XFER_NS 300
`define ESC_SETTLE_NS 150
`define ESC_XFER_CYC ((`ESC_XFER_NS * `ESC_CLK_MHZ + 999) / 1000)
`define ESC_WINDOW_CYC ((`ESC_XFER_NS * `ESC_CLK_MHZ) / 1000)
`define ESC_SETTLE_CYC ((`ESC_SETTLE_NS * `ESC_CLK_MHZ + 999) / 1000)
`define ESC_SILO_DEPTH 64
`define ESC_LINES 8
`define ESC_LPR_LINE_LSB 0
`define ESC_LPR_SPEED_LSB 8
`define ESC_LPR_RXON_BIT 12
`define ESC_BAUD_BASE_DIV 12'h010
`endif

// File: inc/esc_pkg.sv
// Purpose: types of the eight-line serial scanner
// Assumes: nothing beyond the defines header
// Notes: state codes are one-hot
package esc_pkg;
	typedef enum logic [3:0] {PH1 = 4'h1, PH2 = 4'h2, PH3 = 4'h4, PH4 = 4'h8} esc_phase_t;
	typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_PULSE = 3'h2, TX_SETTLE = 3'h4} esc_xfer_t;
	typedef struct packed {
		logic [3:0] cond;
		logic [7:0] ch;
	} esc_uart_rx_t;
	typedef struct packed {
		logic [3:0] cond;
		logic spare;
		logic [2:0] line;
		logic [7:0] ch;
	} esc_silo_word_t;
endpackage

// File: rtl/esc_rx_silo.sv
// Purpose: receive silo, a shift-down store of received words
// Assumes: push only when room is high
// Notes: entry 0 is the word the host sees
`timescale 1ns/1ps
`default_nettype none
`include "esc_defines.svh"
module esc_rx_silo
	import esc_pkg::*;
#(
	parameter int DEPTH = `ESC_SILO_DEPTH
)
(
	input wire logic clk,
	input wire logic clr,
	input wire logic push,
	input wire esc_silo_word_t push_word,
	input wire logic pop,
	output var esc_silo_word_t head,
	output logic present,
	output logic room
);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		esc_silo_word_t [DEPTH-1:0] mem;
		logic [CW-1:0] cnt;
		logic present;
	} esc_silo_st_t;
	esc_silo_st_t s_ff;
	esc_silo_st_t nxt_s;

	assign head = s_ff.mem[0];
	assign present = s_ff.present;
	assign room = (s_ff.cnt != CW'(DEPTH));

	always_comb
	begin
		nxt_s = s_ff;
		if (pop && s_ff.present)
		begin
			nxt_s.mem = {esc_silo_word_t'(16'h0000), s_ff.mem[DEPTH-1:1]}; // [R07]
			nxt_s.cnt = s_ff.cnt - CW'(1);
		end
		// a full silo refuses the push even when a pop frees a slot
		if (push && room)
		begin
			nxt_s.mem[nxt_s.cnt] = push_word; // [R06]
			nxt_s.cnt = nxt_s.cnt + CW'(1);
		end
		nxt_s.present = (nxt_s.cnt != '0); // [R21]
	end

	always_ff @(posedge clk)
	begin
		if (clr)
			s_ff <= '0; // [R24]
		else
			s_ff <= nxt_s;
	end
endmodule
`default_nettype wire

// File: rtl/esc_baud_gen.sv
// Purpose: per-line bit clocks from the master clock tick
// Assumes: master_tick is one cycle wide at the master rate
// Notes: divisor table is a plain linear one
`timescale 1ns/1ps
`default_nettype none
`include "esc_defines.svh"
module esc_baud_gen
	import esc_pkg::*;
#(
	parameter int LINES = `ESC_LINES
)
(
	input wire logic clk,
	input wire logic clr,
	input wire logic master_tick,
	input wire logic param_write,
	input wire logic [15:0] param_data,
	output logic [LINES-1:0] tx_bit_clock,
	output logic [LINES-1:0] rx_bit_clock
);
	typedef struct packed {
		logic [LINES-1:0][3:0] speed;
		logic [LINES-1:0][11:0] cnt;
		logic [LINES-1:0] rx_on;
		logic [LINES-1:0] txc;
		logic [LINES-1:0] rxc;
	} esc_baud_st_t;
	esc_baud_st_t s_ff;
	esc_baud_st_t nxt_s;

	function automatic logic [11:0] esc_divisor(input logic [3:0] sp);
		esc_divisor = 12'(`ESC_BAUD_BASE_DIV * (5'h10 - {1'b0, sp}));
	endfunction

	assign tx_bit_clock = s_ff.txc;
	assign rx_bit_clock = s_ff.rxc;

	always_comb
	begin
		logic [2:0] ln;
		ln = param_data[`ESC_LPR_LINE_LSB +: 3];
		nxt_s = s_ff;
		if (param_write)
		begin
			nxt_s.speed[ln] = param_data[`ESC_LPR_SPEED_LSB +: 4]; // [R19]
			nxt_s.rx_on[ln] = param_data[`ESC_LPR_RXON_BIT]; // [R19]
		end
		for (int i = 0; i < LINES; i++)
		begin
			if (master_tick)
			begin
				if (s_ff.cnt[i] == 12'h000)
				begin
					nxt_s.cnt[i] = esc_divisor(s_ff.speed[i]) - 12'h001;
					nxt_s.txc[i] = ~s_ff.txc[i];
				end
				else
					nxt_s.cnt[i] = s_ff.cnt[i] - 12'h001;
			end
			// receive clock is the transmit clock gated, so both share one rate
			nxt_s.rxc[i] = nxt_s.txc[i] & nxt_s.rx_on[i]; // [R20]
		end
	end

	always_ff @(posedge clk)
	begin
		if (clr)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
endmodule
`default_nettype wire

// File: rtl/esc_scanner.sv
// Purpose: scanner of an eight-line serial multiplexer
// Assumes: all inputs synchronous to clk; host pulses are one cycle
// Notes: the master clock is made by a fractional accumulator off clk
// Notes on behaviour
// [R01] phase clock is the master clock divided by five; master clock also drives baud
// [R02] each line slot lasts 4.0 us, split into four equal phases
// [R03] three-bit line counter steps at phase four to one, all eight lines in turn
// [R04] phase one tests char waiting; with silo room push at phase two start
// [R05] char waiting clear runs through phase three, only after a push
// [R06] silo holds 64 words of 16 bits: char, line, condition bits
// [R07] host read with character present pops silo; next word moves to output
// [R08] scanned line's tx empty and enable are latched into its pending bit
// [R09] pending bits load encoder input only while no line is offered
// [R10] highest pending line wins; its number and any-pending go to host
// [R11] service request only while a line is pending and load flag is clear
// [R12] host transmit write sets load flag and drops service request
// [R13] transfer starts in first 300 ns of a phase, never in phase one
// [R14] 300 ns transfer pulse strobes only the selected line's uart
// [R15] during the pulse the selected line's pending bit is cleared
// [R16] after the pulse encoder is off, reloaded, and waits 150 ns
// [R17] after a transfer flags clear; another pending line is offered again
// [R18] disabling the offered line runs the same sequence without a strobe
// [R19] line parameter write sets speed; receiver-on gates the receive clock
// [R20] transmitter and receiver of a line share one speed setting
// [R21] receive-done follows a non-empty silo and is the receive request
// [R22] transmit request when service request and transmit irq enable
// [R23] host sets each line's enable bit to permit or stop its service
// [R24] reset or device clear empties silo, clears pending, restarts timing
`timescale 1ns/1ps
`default_nettype none
`include "esc_defines.svh"
module esc_scanner
	import esc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic dev_clear,
	input wire logic [7:0] line_enable,
	input wire logic tx_irq_enable,
	input wire logic [7:0] char_waiting_flag,
	input wire esc_uart_rx_t [7:0] uart_rx,
	input wire logic receive_read,
	input wire logic [7:0] uart_tx_empty,
	input wire logic transmit_write,
	input wire logic [7:0] transmit_data,
	input wire logic lpr_write,
	input wire logic [15:0] lpr_data,
	output logic [7:0] char_waiting_clear,
	output var esc_silo_word_t receive_word,
	output logic rx_char_present,
	output logic rx_irq,
	output logic [7:0] transmit_char,
	output logic [7:0] char_load_strobe,
	output logic tx_service_request,
	output logic any_line_pending,
	output logic [2:0] tx_line,
	output logic tx_irq,
	output logic [7:0] tx_bit_clock,
	output logic [7:0] rx_bit_clock
);
	typedef struct packed {
		logic [16:0] acc;
		logic mtick;
		logic [2:0] div;
		esc_phase_t phase;
		logic [5:0] pcyc;
		logic [2:0] line;
		logic pushed;
		logic [7:0] wait_clr;
		logic [7:0] pend;
		logic [7:0] enc_in;
		logic enc_off;
		logic load;
		logic no_strobe;
		esc_xfer_t xs;
		logic [4:0] tcnt;
		logic [7:0] tchar;
		logic [7:0] strobe;
		logic any;
		logic [2:0] tline;
		logic treq;
		logic tirq;
	} esc_scan_st_t;
	esc_scan_st_t s_ff;
	esc_scan_st_t nxt_s;

	logic clr;
	logic silo_push;
	logic silo_pop;
	logic silo_room;
	logic silo_present;
	esc_silo_word_t silo_in;
	esc_silo_word_t silo_head;

	function automatic logic [7:0] esc_line_bit(input logic [2:0] l);
		esc_line_bit = 8'h01 << l;
	endfunction

	// later indices overwrite earlier ones, so the highest pending line wins
	function automatic logic [3:0] esc_prio(input logic [7:0] v);
		esc_prio = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (v[i])
				esc_prio = {1'b1, 3'(i)};
		end
	endfunction

	// either reset source restarts the whole scan from line 0, phase one
	assign clr = sys_rst | dev_clear; // [R24]
	assign silo_in = '{cond: uart_rx[s_ff.line].cond,
		spare: 1'b0,
		line: s_ff.line,
		ch: uart_rx[s_ff.line].ch};
	assign silo_pop = receive_read & silo_present; // [R07]

	assign char_waiting_clear = s_ff.wait_clr;
	assign receive_word = silo_head;
	assign rx_char_present = silo_present;
	assign rx_irq = silo_present; // [R21]
	assign transmit_char = s_ff.tchar;
	assign char_load_strobe = s_ff.strobe;
	assign tx_service_request = s_ff.treq;
	assign any_line_pending = s_ff.any;
	assign tx_line = s_ff.tline;
	assign tx_irq = s_ff.tirq;

	always_comb
	begin
		logic [17:0] sum;
		logic ptick;
		logic [3:0] enc;
		nxt_s = s_ff;
		ptick = 1'b0;
		enc = 4'h0;
		sum = {1'b0, s_ff.acc} + `ESC_MASTER_KHZ;
		// fractional step keeps the average master rate exact
		if (sum >= `ESC_SYS_KHZ)
		begin
			nxt_s.acc = 17'(sum - `ESC_SYS_KHZ);
			nxt_s.mtick = 1'b1;
		end
		else
		begin
			nxt_s.acc = sum[16:0];
			nxt_s.mtick = 1'b0;
		end
		// the divider moves only on a master tick; the phase steps on every fifth
		ptick = nxt_s.mtick && (s_ff.div == `ESC_PHASE_DIV - 3'h1); // [R01]
		if (nxt_s.mtick)
			nxt_s.div = ptick ? 3'h0 : s_ff.div + 3'h1; // [R01]
		// the phase cycle count saturates, so a long phase never wraps into the window
		silo_push = 1'b0;
		if (ptick)
		begin
			nxt_s.pcyc = 6'h00;
			case (s_ff.phase) // [R02]
				PH1:
				begin
					nxt_s.phase = PH2;
					silo_push = char_waiting_flag[s_ff.line] & silo_room; // [R04]
					nxt_s.pushed = silo_push;
				end
				PH2:
				begin
					nxt_s.phase = PH3;
					nxt_s.wait_clr = s_ff.pushed ? esc_line_bit(s_ff.line) : 8'h00; // [R05]
				end
				PH3:
				begin
					nxt_s.phase = PH4;
					nxt_s.wait_clr = 8'h00; // [R05]
				end
				PH4:
				begin
					nxt_s.phase = PH1;
					nxt_s.pushed = 1'b0;
					nxt_s.line = s_ff.line + 3'h1; // [R03]
				end
				default:
				begin
					nxt_s.phase = PH1;
				end
			endcase
		end
		else if (s_ff.pcyc != 6'h3F)
			nxt_s.pcyc = s_ff.pcyc + 6'h01;

		// the scanned line is sampled in phase one, the offered line cleared later
		if (s_ff.phase == PH1)
			nxt_s.pend[s_ff.line] = uart_tx_empty[s_ff.line] & line_enable[s_ff.line]; // [R08]
		if (s_ff.xs == TX_PULSE)
			nxt_s.pend[s_ff.tline] = 1'b0; // [R15]

		case (s_ff.xs)
			TX_IDLE:
			begin
				if (s_ff.load && s_ff.phase != PH1 && s_ff.pcyc < 6'(`ESC_WINDOW_CYC)) // [R13]
				begin
					nxt_s.xs = TX_PULSE;
					// widths round up, so the pulse never falls short of its time
					nxt_s.tcnt = 5'(`ESC_XFER_CYC - 1);
					// a disabled or absent line runs the same sequence but strobes no uart
					nxt_s.strobe = (s_ff.no_strobe || !s_ff.any) ? 8'h00
						: esc_line_bit(s_ff.tline); // [R14]
				end
			end
			TX_PULSE:
			begin
				if (s_ff.tcnt == 5'h00)
				begin
					nxt_s.xs = TX_SETTLE;
					nxt_s.strobe = 8'h00; // [R14]
					// encoder stays dark while its inputs settle, so no half-loaded line shows
					nxt_s.enc_off = 1'b1; // [R16]
					nxt_s.enc_in = nxt_s.pend; // [R16]
					nxt_s.load = 1'b0; // [R17]
					nxt_s.no_strobe = 1'b0; // [R17]
					nxt_s.tcnt = 5'(`ESC_SETTLE_CYC - 1);
				end
				else
					nxt_s.tcnt = s_ff.tcnt - 5'h01;
			end
			TX_SETTLE:
			begin
				if (s_ff.tcnt == 5'h00)
				begin
					nxt_s.xs = TX_IDLE;
					nxt_s.enc_off = 1'b0; // [R16]
				end
				else
					nxt_s.tcnt = s_ff.tcnt - 5'h01;
			end
			default:
			begin
				nxt_s.xs = TX_IDLE;
			end
		endcase

		// placed after the flag clear so a write in the same cycle is kept
		// a write wins over the disable path, so a written character is never dropped
		if (transmit_write)
		begin
			nxt_s.tchar = transmit_data;
			nxt_s.load = 1'b1; // [R12]
			nxt_s.no_strobe = 1'b0;
		end
		else if (s_ff.any && !s_ff.load && !line_enable[s_ff.tline])
		begin
			nxt_s.load = 1'b1; // [R18]
			nxt_s.no_strobe = 1'b1; // [R18]
		end

		if (!s_ff.any && s_ff.xs == TX_IDLE)
			nxt_s.enc_in = nxt_s.pend; // [R09]
		enc = esc_prio(nxt_s.enc_in); // [R10]
		nxt_s.any = enc[3] & ~nxt_s.enc_off; // [R10]
		nxt_s.tline = enc[2:0]; // [R10]
		nxt_s.treq = nxt_s.any & ~nxt_s.load; // [R11]
		// built from the next request so request and interrupt flops move together
		nxt_s.tirq = nxt_s.treq & tx_irq_enable; // [R22]
	end

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			// all-zero is no legal one-hot code, so both state fields are set apart
			s_ff <= '0; // [R24]
			s_ff.phase <= PH1;
			s_ff.xs <= TX_IDLE;
		end
		else
			s_ff <= nxt_s;
	end

	// the silo shares the scanner's clear, so no stale word outlives a device clear
	esc_rx_silo #(
		.DEPTH(`ESC_SILO_DEPTH)
	) esc_rx_silo_inst (
		.clk(clk),
		.clr(clr),
		.push(silo_push),
		.push_word(silo_in),
		.pop(silo_pop),
		.head(silo_head),
		.present(silo_present),
		.room(silo_room)
	);

	// bit clocks run off the same master tick as the phase divider
	esc_baud_gen #(
		.LINES(`ESC_LINES)
	) esc_baud_gen_inst (
		.clk(clk),
		.clr(clr),
		.master_tick(s_ff.mtick),
		.param_write(lpr_write),
		.param_data(lpr_data),
		.tx_bit_clock(tx_bit_clock),
		.rx_bit_clock(rx_bit_clock)
	);
endmodule
`default_nettype wire

// File: tb/esc_scanner_props.sv
// Purpose: port checker for esc_scanner
// Assumes: 100 MHz clk, 30 cycle transfer pulse
// Notes: device clear pauses most checks
`timescale 1ns/1ps
`default_nettype none
module esc_scanner_props
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic dev_clear,
	input wire logic transmit_write,
	input wire logic [7:0] char_waiting_clear,
	input wire logic rx_char_present,
	input wire logic rx_irq,
	input wire logic [7:0] char_load_strobe,
	input wire logic tx_service_request,
	input wire logic any_line_pending
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || dev_clear);
	sequence s_pulse;
		##29 (|char_load_strobe) ##1 !(|char_load_strobe);
	endsequence
	sequence s_settle;
		##2 !any_line_pending [*8];
	endsequence
	property p_pulse; $rose(|char_load_strobe) |-> s_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe length wrong");
	property p_settle; $fell(|char_load_strobe) |-> s_settle; endproperty
	a_settle: assert property (p_settle) else $error("encoder not off");
	property p_one; |char_load_strobe |-> $onehot(char_load_strobe); endproperty
	a_one: assert property (p_one) else $error("strobe not one-hot");
	property p_drop; transmit_write |=> !tx_service_request; endproperty
	a_drop: assert property (p_drop) else $error("request kept");
	property p_req; tx_service_request |-> any_line_pending; endproperty
	a_req: assert property (p_req) else $error("request without pending");
	property p_busy; |char_load_strobe |-> !tx_service_request; endproperty
	a_busy: assert property (p_busy) else $error("request in transfer");
	property p_cwc; $rose(|char_waiting_clear) |-> $onehot(char_waiting_clear) [*8]; endproperty
	a_cwc: assert property (p_cwc) else $error("clear pulse short");
	property p_irq; rx_irq == rx_char_present; endproperty
	a_irq: assert property (p_irq) else $error("rx irq differs");
	property p_clr;
		disable iff (sys_rst) dev_clear |=> !rx_char_present && !tx_service_request
			&& char_load_strobe == 8'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("clear left state");
endmodule
bind esc_scanner esc_scanner_props esc_scanner_props_inst (.clk(clk), .sys_rst(sys_rst),
	.dev_clear(dev_clear), .transmit_write(transmit_write),
	.char_waiting_clear(char_waiting_clear), .rx_char_present(rx_char_present),
	.rx_irq(rx_irq), .char_load_strobe(char_load_strobe),
	.tx_service_request(tx_service_request), .any_line_pending(any_line_pending));
`default_nettype wire

// File: tb/esc_uart_bank.sv
// Purpose: eight line uart bank seen by the scanner
// Assumes: arrive and tx_done are one-cycle pulses
// Notes: flags hold until the scanner clears them
`timescale 1ns/1ps
`default_nettype none
module esc_uart_bank
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] arrive,
	input wire logic [7:0] tx_done,
	input wire logic [7:0] char_waiting_clear,
	input wire logic [7:0] char_load_strobe,
	output logic [7:0] char_waiting_flag,
	output logic [7:0] uart_tx_empty
);
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			char_waiting_flag <= 8'h00;
			uart_tx_empty <= 8'hFF;
		end
		else
		begin
			char_waiting_flag <= (char_waiting_flag & ~char_waiting_clear) | arrive;
			// a loaded transmitter stays busy until told otherwise
			uart_tx_empty <= (uart_tx_empty & ~char_load_strobe) | tx_done;
		end
	end
endmodule
`default_nettype wire

// File: tb/test_esc_scanner.sv
// Purpose: self-checking bench for esc_scanner
// Assumes: 100 MHz clk, inputs change on falling edge
// Notes: scan waits are bounded at 4000 cycles, a little more than one full scan; strobe waits at 200
`timescale 1ns/1ps
`default_nettype none
module test_esc_scanner
	import esc_pkg::*;
;
	logic clk, sys_rst, dev_clear, tx_irq_enable, receive_read, transmit_write, lpr_write;
	logic [7:0] line_enable, arrive, char_waiting_flag, uart_tx_empty, transmit_data;
	logic [7:0] char_waiting_clear, transmit_char, char_load_strobe, tx_bit_clock, rx_bit_clock;
	logic [15:0] lpr_data;
	logic rx_char_present, rx_irq, tx_service_request, any_line_pending, tx_irq;
	logic [2:0] tx_line;
	esc_uart_rx_t [7:0] uart_rx;
	esc_silo_word_t receive_word;
	int n_fail = 0;
	int tests_run = 0;
	esc_scanner esc_scanner_inst (.clk(clk), .sys_rst(sys_rst), .dev_clear(dev_clear),
		.line_enable(line_enable), .tx_irq_enable(tx_irq_enable),
		.char_waiting_flag(char_waiting_flag), .uart_rx(uart_rx), .receive_read(receive_read),
		.uart_tx_empty(uart_tx_empty), .transmit_write(transmit_write),
		.transmit_data(transmit_data), .lpr_write(lpr_write), .lpr_data(lpr_data),
		.char_waiting_clear(char_waiting_clear), .receive_word(receive_word),
		.rx_char_present(rx_char_present), .rx_irq(rx_irq), .transmit_char(transmit_char),
		.char_load_strobe(char_load_strobe), .tx_service_request(tx_service_request),
		.any_line_pending(any_line_pending), .tx_line(tx_line), .tx_irq(tx_irq),
		.tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock));
	esc_uart_bank esc_uart_bank_inst (.clk(clk), .sys_rst(sys_rst), .arrive(arrive),
		.tx_done(8'h00), .char_waiting_clear(char_waiting_clear),
		.char_load_strobe(char_load_strobe), .char_waiting_flag(char_waiting_flag),
		.uart_tx_empty(uart_tx_empty));
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	task wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task offer(input logic [2:0] l);
		for (int i = 0; i < 4000 && tx_service_request !== 1'b1; i++) @(negedge clk);
		chk("offered line", {tx_service_request, tx_line}, {1'b1, l});
	endtask
	task xfer(input logic [7:0] d, input logic [7:0] s);
		transmit_data = d;
		transmit_write = 1;
		@(negedge clk);
		transmit_write = 0;
		chk("req after write", tx_service_request, 1'b0);
		for (int i = 0; i < 200 && char_load_strobe === 8'h00; i++) @(negedge clk);
		chk("strobe", char_load_strobe, s);
		chk("char", transmit_char, d);
	endtask
	task t_rx;
		arrive = 8'h24;
		@(negedge clk);
		arrive = 8'h00;
		for (int i = 0; i < 4000 && rx_char_present !== 1'b1; i++) @(negedge clk);
		chk("first word", receive_word, 16'h22A2);
		for (int i = 0; i < 4000 && char_waiting_flag[5] !== 1'b0; i++) @(negedge clk);
		chk("flags cleared", char_waiting_flag, 8'h00);
		receive_read = 1;
		@(negedge clk);
		receive_read = 0;
		chk("next word", receive_word, 16'h55A5);
		receive_read = 1;
		@(negedge clk);
		receive_read = 0;
		chk("silo empty", rx_char_present, 1'b0);
	endtask
	task t_tx;
		int n;
		line_enable = 8'h01;
		offer(3'd0);
		line_enable = 8'hA5;
		// one full scan so every enabled line is latched pending
		repeat (3300) @(negedge clk);
		chk("offer held", tx_line, 3'd0);
		chk("tx irq", tx_irq, 1'b1);
		tx_irq_enable = 0;
		@(negedge clk);
		chk("tx irq masked", tx_irq, 1'b0);
		tx_irq_enable = 1;
		xfer(8'h5A, 8'h01);
		offer(3'd7);
		xfer(8'hC3, 8'h80);
		offer(3'd5);
		line_enable = 8'h85;
		n = 0;
		for (int i = 0; i < 4000 && !(tx_service_request === 1'b1 && tx_line === 3'd2); i++)
		begin
			n += (char_load_strobe !== 8'h00);
			@(negedge clk);
		end
		chk("after disable", {tx_service_request, tx_line}, {1'b1, 3'd2});
		chk("no strobe", n, 0);
	endtask
	task t_lpr;
		logic r, p;
		int t;
		lpr_data = 16'h0F03;
		lpr_write = 1;
		@(negedge clk);
		lpr_write = 0;
		r = 0;
		t = 0;
		p = tx_bit_clock[3];
		// the old slow half period must run out before the new rate shows
		for (int i = 0; i < 6400; i++)
		begin
			r = r | rx_bit_clock[3];
			t += (tx_bit_clock[3] !== p);
			p = tx_bit_clock[3];
			@(negedge clk);
		end
		chk("rx clock off", r, 1'b0);
		chk("tx clock runs", t >= 4, 1'b1);
		lpr_data = 16'h1F03;
		lpr_write = 1;
		@(negedge clk);
		lpr_write = 0;
		r = 0;
		for (int i = 0; i < 800; i++)
		begin
			r = r | (rx_bit_clock[3] !== tx_bit_clock[3]);
			@(negedge clk);
		end
		chk("rx follows tx", r, 1'b0);
	endtask
	task t_clear;
		arrive = 8'h01;
		@(negedge clk);
		arrive = 8'h00;
		for (int i = 0; i < 4000 && rx_char_present !== 1'b1; i++) @(negedge clk);
		chk("clear setup", rx_char_present, 1'b1);
		dev_clear = 1;
		@(negedge clk);
		dev_clear = 0;
		chk("clear silo", rx_char_present, 1'b0);
	endtask
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#400000;
		n_fail++;
		wrap_up;
	end
	initial
	begin
		{dev_clear, receive_read, transmit_write, lpr_write} = 4'h0;
		{line_enable, arrive, transmit_data, lpr_data} = 40'h0;
		tx_irq_enable = 1;
		for (int k = 0; k < 8; k++) uart_rx[k] = {4'(k), 8'(160 + k)};
		sys_rst = 1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		sys_rst = 0;
		chk("reset", {rx_char_present, tx_service_request, char_load_strobe}, 16'h0000);
		t_rx;
		t_tx;
		t_lpr;
		t_clear;
		wrap_up;
	end
endmodule
`default_nettype wire
